// >>> rofw_cfg.svh
/*
 Timing counts, baud constants and reset values for the output fault
 watchdog. Assumes a 50 MHz system clock.
*/
`ifndef ROFW_CFG_SVH
`define ROFW_CFG_SVH
`define ROFW_CLK_HZ          50000000
`define ROFW_MS_NS           1000000
`define ROFW_CLK_NS          20
`define ROFW_MS_CYCLES       (`ROFW_MS_NS / `ROFW_CLK_NS)
`define ROFW_WD_MS_RST       16'h0032
`define ROFW_SETUP_BAUD      115200
`define ROFW_OPER_BAUD       2500000
`define ROFW_SETUP_DIV       ((`ROFW_CLK_HZ + `ROFW_SETUP_BAUD - 1) / `ROFW_SETUP_BAUD)
`define ROFW_OPER_DIV        (`ROFW_CLK_HZ / `ROFW_OPER_BAUD)
`define ROFW_FLT_SHORT_BIT   0
`define ROFW_FLT_OTEMP_BIT   1
`define ROFW_FLT_WDOG_BIT    2
`define ROFW_FLT_FIELD_BIT   3
`endif

// >>> rofw_pkg.sv
/*
 Types for the output fault watchdog: process data modes and the
 packed answer returned on each host transfer.
*/
package rofw_pkg;
   typedef enum logic [0:0] {
      ROFW_PD_OUT_ONLY,
      ROFW_PD_OUT_FIELD
   } rofw_pd_mode_t;

   typedef struct packed {
      logic [47:0] in_data;
      logic [7:0]  fault;
      logic [15:0] field_mv;
      logic        field_valid;
   } rofw_answer_t;
endpackage

// >>> rofw_watchdog.sv
/*
 Output gating, fault latching, communication watchdog and baud
 selection for a remote 48-output card.
 Assumes a decoded host access stream in the clk_sys_i domain, driver
 chip status pins synchronous to clk_sys_i, and a field ADC word.
*/
// How it works
// - Setup mode uses a fixed 115.2 kbaud divisor, not changeable.
// - Jumper up gives operate mode, 2.5 Mbps default, reconfigurable.
// - Short-circuit report disables that one output, raises a fault.
// - Chip overtemperature flag disables all that chip's outputs.
// - Each driver chip owns eight consecutive output bits.
// - No host access within watchdog period sets fault; 50 ms default.
// - Host must access faster than period; expiry turns outputs off.
// - While faulted, output writes are ignored until host clears.
// - Fault flag is set out of reset; host clears before use.
// - Field voltage reported in modes with it; loss flagged only with separate logic supply.
// - Each transfer returns 48 input bits and 8 fault bits.
// - Link supports 10 kHz updates at 2.5 Mbaud.
// - Period counted in ms; zero disables the watchdog.
// - Mode 0 carries outputs only; mode 1 adds field voltage.
`timescale 1ns/1ps
`include "rofw_cfg.svh"

module rofw_watchdog #(
   parameter int NUM_OUT  = 48,
   parameter int CHIP_W   = 8,
   parameter int MS_CYC   = `ROFW_MS_CYCLES,
   parameter int DIV_W    = 16
) (
   input  wire logic                  clk_sys_i,
   input  wire logic                  rst_i,
   input  wire logic                  mode_select_jumper_i,
   input  wire logic                  logic_supply_separate_i,
   input  wire logic                  host_access_i,
   input  wire logic                  host_write_out_i,
   input  wire logic [NUM_OUT-1:0]    host_out_data_i,
   input  wire logic                  host_clear_fault_i,
   input  wire logic                  host_set_wd_i,
   input  wire logic [15:0]           host_wd_ms_i,
   input  wire logic                  host_set_baud_i,
   input  wire logic [DIV_W-1:0]      host_baud_div_i,
   input  wire logic                  host_set_mode_i,
   input  wire logic                  host_pd_mode_i,
   input  wire logic [NUM_OUT-1:0]    in_data_i,
   input  wire logic [NUM_OUT-1:0]    short_i,
   input  wire logic [NUM_OUT/8-1:0]  otemp_i,
   input  wire logic [15:0]           field_supply_mv_i,
   input  wire logic                  field_supply_ok_i,
   output logic [NUM_OUT-1:0]         out_drive_o,
   output logic                       fault_o,
   output logic                       setup_mode_o,
   output logic [DIV_W-1:0]           baud_div_o,
   output rofw_pkg::rofw_answer_t     answer_o
);
   localparam int NCHIP = NUM_OUT / CHIP_W;

   initial begin
      if (CHIP_W != 8 || NUM_OUT % CHIP_W != 0 || NUM_OUT > 48 ||
          MS_CYC < 1)
         $error("rofw_watchdog: unsupported parameters");
   end

   ////////////////////////////////////////////////////////////////////
   // State
   logic [NUM_OUT-1:0]      out_req_q, out_req_d;
   logic [NUM_OUT-1:0]      short_lat_q, short_lat_d;
   logic [NCHIP-1:0]        otemp_lat_q, otemp_lat_d;
   logic                    wd_flt_q, wd_flt_d;
   logic [15:0]             wd_ms_q, wd_ms_d;
   logic [15:0]             ms_left_q, ms_left_d;
   logic [31:0]             tick_q, tick_d;
   logic [DIV_W-1:0]        oper_div_q, oper_div_d;
   rofw_pkg::rofw_pd_mode_t pd_mode_q, pd_mode_d;
   logic [NUM_OUT-1:0]      drive_d;
   logic [NUM_OUT-1:0]      chip_block;
   logic                    fault_any;
   rofw_pkg::rofw_answer_t  ans_d;

   always_comb begin
      for (int i = 0; i < NUM_OUT; i++)
         chip_block[i] = otemp_lat_q[i / CHIP_W];
   end

   ////////////////////////////////////////////////////////////////////
   // Next state
   always_comb begin
      out_req_d   = out_req_q;
      short_lat_d = short_lat_q;
      otemp_lat_d = otemp_lat_q;
      wd_flt_d    = wd_flt_q;
      wd_ms_d     = wd_ms_q;
      ms_left_d   = ms_left_q;
      tick_d      = tick_q;
      oper_div_d  = oper_div_q;
      pd_mode_d   = pd_mode_q;

      if (host_set_wd_i)
         wd_ms_d = host_wd_ms_i;
      if (host_set_baud_i && host_baud_div_i != '0)
         oper_div_d = host_baud_div_i;
      if (host_set_mode_i)
         pd_mode_d = rofw_pkg::rofw_pd_mode_t'(host_pd_mode_i);

      if (host_clear_fault_i) begin
         short_lat_d = '0;
         otemp_lat_d = '0;
         wd_flt_d    = 1'b0;
      end
      short_lat_d = short_lat_d | short_i;
      otemp_lat_d = otemp_lat_d | otemp_i;

      if (host_write_out_i && !fault_any)
         out_req_d = host_out_data_i;

      if (host_access_i || host_clear_fault_i) begin
         ms_left_d = wd_ms_d;
         tick_d    = 32'(MS_CYC - 1);
      end else if (wd_ms_q != '0 && !wd_flt_q) begin
         if (tick_q == '0) begin
            tick_d = 32'(MS_CYC - 1);
            if (ms_left_q <= 16'h0001) begin
               wd_flt_d  = 1'b1;
               ms_left_d = wd_ms_q;
            end else begin
               ms_left_d = ms_left_q - 16'h0001;
            end
         end else begin
            tick_d = tick_q - 32'h1;
         end
      end
   end

   assign fault_any = wd_flt_q | (|short_lat_q) | (|otemp_lat_q);

   always_comb begin
      drive_d = wd_flt_q ? '0 : (out_req_q & ~short_lat_q & ~chip_block);
      ans_d = '0;
      // 48 inputs and 8 fault bits
      ans_d.in_data[NUM_OUT-1:0] = in_data_i;
      ans_d.fault[`ROFW_FLT_SHORT_BIT] = |short_lat_q;
      ans_d.fault[`ROFW_FLT_OTEMP_BIT] = |otemp_lat_q;
      ans_d.fault[`ROFW_FLT_WDOG_BIT]  = wd_flt_q;
      // field loss with separate logic supply
      ans_d.fault[`ROFW_FLT_FIELD_BIT] =
         logic_supply_separate_i & ~field_supply_ok_i;
      if (pd_mode_q == rofw_pkg::ROFW_PD_OUT_FIELD) begin
         ans_d.field_mv    = field_supply_mv_i;
         ans_d.field_valid = 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Registers
   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         out_req_q    <= '0;
         short_lat_q  <= '0;
         otemp_lat_q  <= '0;
         wd_flt_q     <= 1'b1;
         wd_ms_q      <= `ROFW_WD_MS_RST;
         ms_left_q    <= `ROFW_WD_MS_RST;
         tick_q       <= '0;
         oper_div_q   <= DIV_W'(`ROFW_OPER_DIV);
         pd_mode_q    <= rofw_pkg::ROFW_PD_OUT_ONLY;
         out_drive_o  <= '0;
         fault_o      <= 1'b1;
         setup_mode_o <= 1'b0;
         baud_div_o   <= DIV_W'(`ROFW_OPER_DIV);
         answer_o     <= '0;
      end else begin
         out_req_q    <= out_req_d;
         short_lat_q  <= short_lat_d;
         otemp_lat_q  <= otemp_lat_d;
         wd_flt_q     <= wd_flt_d;
         wd_ms_q      <= wd_ms_d;
         ms_left_q    <= ms_left_d;
         tick_q       <= tick_d;
         oper_div_q   <= oper_div_d;
         pd_mode_q    <= pd_mode_d;
         out_drive_o  <= drive_d;
         fault_o      <= fault_any;
         setup_mode_o <= ~mode_select_jumper_i;
         baud_div_o   <= mode_select_jumper_i ? oper_div_q :
                         DIV_W'(`ROFW_SETUP_DIV);
         answer_o     <= ans_d;
      end
   end
endmodule

// >>> rofw_host_model.sv
/* Host stand-in: pulses a valid access every GAP cycles while enabled.
   Assumes the bench enables it only while the card is to be fed. */
`timescale 1ns/1ps
module rofw_host_model #(parameter int GAP = 100) (
   input  wire logic clk_sys_i,
   input  wire logic en_i,
   output logic      access_o = 1'b0
);
   int cnt_q = 0;
   always @(negedge clk_sys_i) begin
      cnt_q <= (cnt_q == GAP - 1) ? 0 : cnt_q + 1;
      access_o <= en_i && cnt_q == 0;
   end
endmodule

// >>> rofw_monitor.sv
/* Checker for the output fault watchdog, bound to rofw_watchdog.
   Assumes the field supply stays good. */
`timescale 1ns/1ps
module rofw_monitor #(parameter int MS_CYC = 10) (
   input wire logic        clk_sys_i,
   input wire logic        rst_i,
   input wire logic        mode_select_jumper_i,
   input wire logic        host_access_i,
   input wire logic        host_write_out_i,
   input wire logic        host_clear_fault_i,
   input wire logic        host_set_wd_i,
   input wire logic [15:0] host_wd_ms_i,
   input wire logic [47:0] short_i,
   input wire logic [5:0]  otemp_i,
   input wire logic [47:0] out_drive_o,
   input wire logic        fault_o,
   input wire logic [15:0] baud_div_o
);
   localparam int BITE = 50 * MS_CYC + 3;
   int   idle_q;
   logic off_q;
   default clocking @(posedge clk_sys_i); endclocking
   default disable iff (rst_i);
   // Cycles since the last host access, fault clear or watchdog period write
   always_ff @(posedge clk_sys_i) begin
      idle_q <= (rst_i || host_access_i || host_clear_fault_i
                 || host_set_wd_i) ? 0 : idle_q + 1;
      if (rst_i || host_set_wd_i)
         off_q <= !rst_i && host_wd_ms_i == 16'h0000;
   end
   chk_reset_state: assert property (
      $fell(rst_i) |-> fault_o && out_drive_o == 48'h0)
      else $error("outputs live after reset");
   chk_setup_baud: assert property (
      !mode_select_jumper_i [*4] |-> baud_div_o == 16'h01b3)
      else $error("setup divisor wrong");
   chk_short_off: assert property (
      short_i != 48'h0 |=> ##1
      (out_drive_o & $past(short_i, 2)) == 48'h0 && fault_o)
      else $error("shorted output still driven");
   chk_chip_off: assert property (
      otemp_i[2] |=> ##1 out_drive_o[23:16] == 8'h00 && fault_o)
      else $error("hot chip still driven");
   chk_fault_latch: assert property (
      fault_o && !$past(host_clear_fault_i) |=> fault_o)
      else $error("fault dropped without clear");
   chk_write_block: assert property (
      fault_o && !$past(host_clear_fault_i) && host_write_out_i |=> ##1
      (out_drive_o & ~$past(out_drive_o, 2)) == 48'h0)
      else $error("write taken while faulted");
   chk_clear_ok: assert property (
      host_clear_fault_i && short_i == 48'h0 && otemp_i == 6'h00
      |=> ##1 !fault_o)
      else $error("clear not taken");
   chk_wdog_bite: assert property (
      idle_q == BITE && !off_q |-> fault_o && out_drive_o == 48'h0)
      else $error("watchdog did not bite");
   cover property (short_i != 48'h0);
   cover property (otemp_i != 6'h00);
   cover property (idle_q == BITE && !off_q);
endmodule
bind rofw_watchdog rofw_monitor #(.MS_CYC(MS_CYC)) u_mon (.*);

// >>> tb.sv
/* Bench for the output fault watchdog with a host stand-in.
   Assumes MS_CYC of 10: a 50 ms period is 500 cycles. */
`timescale 1ns/1ps
module tb;
   logic        clk_sys_i = 1'b0, rst_i = 1'b1, jmp = 1'b1, feed = 1'b0;
   logic        wr = 1'b0, clr = 1'b0, sw = 1'b0, sb = 1'b0, acc, flt, sm;
   logic [15:0] ms = 16'h0032, bd;
   logic [47:0] dat = 48'h123456789abc, sh = 48'h0, drv;
   logic [5:0]  ot = 6'h00;
   logic        smd = 1'b0, pdm = 1'b0, lsep = 1'b0, fok = 1'b1;
   rofw_pkg::rofw_answer_t ans;
   int          fail_count = 0, total_checks = 0, cyc = 0;
   always #10 clk_sys_i = ~clk_sys_i;
   rofw_host_model #(.GAP(100)) host (
      .clk_sys_i, .en_i(feed), .access_o(acc));
   rofw_watchdog #(.MS_CYC(10)) uut (
      .clk_sys_i, .rst_i, .mode_select_jumper_i(jmp),
      .logic_supply_separate_i(lsep), .host_access_i(acc),
      .host_write_out_i(wr), .host_out_data_i(dat), .host_clear_fault_i(clr),
      .host_set_wd_i(sw), .host_wd_ms_i(ms), .host_set_baud_i(sb),
      .host_baud_div_i(ms), .host_set_mode_i(smd), .host_pd_mode_i(pdm),
      .in_data_i(dat), .short_i(sh), .otemp_i(ot), .field_supply_mv_i(ms),
      .field_supply_ok_i(fok), .out_drive_o(drv), .fault_o(flt),
      .setup_mode_o(sm), .baud_div_o(bd), .answer_o(ans));
   task automatic chk(input logic [47:0] s, e);
      total_checks++;
      if (s !== e) begin
         fail_count++;
         $display("mismatch t=%0t seen=%h exp=%h", $time, s, e);
      end
   endtask
   task automatic step(input int n);
      repeat (n) @(negedge clk_sys_i);
   endtask
   task automatic clear_write(input logic [47:0] v);
      clr = 1'b1;
      step(1);
      clr = 1'b0;
      dat = v;
      wr = 1'b1;
      step(1);
      wr = 1'b0;
      step(3);
   endtask
   task automatic give_verdict;
      $display("checks %0d mismatches %0d", total_checks, fail_count);
      if (fail_count == 0 && total_checks > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   task automatic t_start;
      chk(flt, 1'b1);
      chk(bd, 16'h0014);
      wr = 1'b1;
      step(1);
      wr = 1'b0;
      step(3);
      chk(drv, 48'h0);
      chk(ans.in_data, dat);
   endtask
   task automatic t_fault;
      clear_write('1);
      chk(drv, '1);
      sh[5] = 1'b1;
      step(1);
      sh[5] = 1'b0;
      step(3);
      chk(drv, 48'hffffffffffdf);
      chk(flt, 1'b1);
      clear_write('1);
      ot[2] = 1'b1;
      step(1);
      ot[2] = 1'b0;
      step(3);
      chk(drv, 48'hffffff00ffff);
      chk(ans.fault[1:0], 2'h2);
   endtask
   task automatic t_wdog;
      feed = 1'b1;
      clear_write(48'h00ff00ff00ff);
      step(800);
      chk({flt, drv}, 49'h000ff00ff00ff);
      feed = 1'b0;
      step(520);
      chk({flt, drv}, 49'h1000000000000);
   endtask
   task automatic t_wd_off;
      ms = 16'h0000;
      sw = 1'b1;
      step(1);
      sw = 1'b0;
      clear_write(48'h00000000a5a5);
      step(700);
      chk({flt, drv}, 49'h000000000a5a5);
      ms = 16'h0032;
      sw = 1'b1;
      step(1);
      sw = 1'b0;
   endtask
   task automatic t_field;
      pdm = 1'b1;
      smd = 1'b1;
      step(1);
      smd = 1'b0;
      step(2);
      chk({ans.field_valid, ans.field_mv}, 17'h10032);
      lsep = 1'b1;
      fok = 1'b0;
      step(2);
      chk(ans.fault[3], 1'b1);
      lsep = 1'b0;
      fok = 1'b1;
      step(2);
      chk(ans.fault[3], 1'b0);
   endtask
   task automatic t_baud;
      sb = 1'b1;
      step(1);
      sb = 1'b0;
      step(2);
      chk(bd, 16'h0032);
      jmp = 1'b0;
      step(4);
      chk({sm, bd}, 17'h101b3);
      sb = 1'b1;
      step(1);
      sb = 1'b0;
      step(2);
      chk(bd, 16'h01b3);
   endtask
   always @(posedge clk_sys_i) begin
      cyc++;
      if (cyc == 5000) begin
         fail_count++;
         give_verdict();
      end
   end
   initial begin
      step(12);
      rst_i = 1'b0;
      step(2);
      t_start();
      t_fault();
      t_wdog();
      t_wd_off();
      t_field();
      t_baud();
      give_verdict();
   end
endmodule
